// File: xfer_event_pkg.sv
// Package: constants, register map and carrier types of the event-count transfer front end
package xfer_event_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_EVENT_CTRL     = 4'h0;
  localparam logic [3:0] OFS_COUNTER_CTRL   = 4'h1;
  localparam logic [3:0] OFS_PENDING        = 4'h2;
  localparam logic [3:0] OFS_ENABLE_C       = 4'h3;
  localparam logic [3:0] OFS_SOFT_VECTOR    = 4'h4;
  localparam logic [3:0] OFS_PORT_DIR       = 4'h5;
  localparam logic [3:0] OFS_STATUS         = 4'h6;
  localparam logic [3:0] OFS_DONE_COUNT     = 4'h7;

  // Field positions
  localparam int EVENT_ENABLE_BIT    = 7;
  localparam int EDGE_SELECT_BIT     = 7;
  localparam int EVENT_ACT_EN_BIT    = 4;
  localparam int SOFT_START_BIT      = 7;

  // Reset values
  localparam logic [7:0] RST_EVENT_CTRL   = 8'h00;
  localparam logic [7:0] RST_COUNTER_CTRL = 8'h00;
  localparam logic [7:0] RST_ENABLE_C     = 8'h00;
  localparam logic [7:0] RST_SOFT_VECTOR  = 8'h00;
  localparam logic [7:0] RST_PORT_DIR     = 8'h00;

  // Vector table layout
  localparam logic [15:0] VECTOR_BASE       = 16'h0400;
  localparam logic [6:0]  EVENT_VECTOR_NUM  = 7'h1D;
  localparam logic [23:0] INFO_PAGE         = 24'hFF0000;
  localparam logic [4:0]  SLOT_MASK_CLEAR   = 5'h00;

  // Number of register-information words read per job
  localparam logic [2:0] INFO_WORDS         = 3'h6;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'b0000,
    ST_VEC_READ   = 4'b0001,
    ST_INFO_READ  = 4'b0010,
    ST_DATA_READ  = 4'b0011,
    ST_DATA_WRITE = 4'b0100,
    ST_INFO_WRITE = 4'b0101,
    ST_FINISH     = 4'b0110
  } xfer_state_t;

  // Register port from the processor
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // RAM request towards on-chip RAM (word access, data taken in the cycle the request stands)
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        rd;
    logic        wr;
  } ram_req_t;

endpackage

// File: xfer_event_counter.sv
// Activation front end and event-count transfer sequencer
`timescale 1ns/1ns

// Overview of operation
// RULE_01: Software programs mode A fixed/fixed, repeat mode, destination repeat, word size.
// RULE_02: Software sets bit 4 of enable register C to allow event activation.
// RULE_03: Source and destination hold one RAM address with low five bits zero.
// RULE_04: Enabled pin seeing selected edge sets its pending flag; code derived.
// RULE_05: Event request is high while any pending flag is set.
// RULE_06: Event request starts read, increment, write back at the same address.
// RULE_07: Low five address bits become twice the serviced flag index.
// RULE_08: Completed increment clears the serviced pending flag.
// RULE_09: Lowest-numbered pending pin is serviced first.
// RULE_10: Edges on a pin already pending are lost, not queued.
// RULE_11: Count wraps to zero on overflow with no interrupt.
// RULE_12: Controller starts on a selected request or a software vector write.
// RULE_13: End of transfer clears the activating flag or its enable bit.
// RULE_14: Routed requests ignore processor mask level and interrupt priorities.
// RULE_15: Software activation first, then sources by ascending vector number.
// RULE_16: Register information sits in on-chip RAM window at four-byte multiples.
// RULE_17: Information order: mode A, source, mode B, destination, count A, count B.
// RULE_18: Chained sets lie back to back; vector holds first start address.
// RULE_19: Fetch start address from vector entry, then read register information.
// RULE_20: Software vector address is base plus twice the seven-bit vector number.
// RULE_21: Vector entries are two bytes holding the low start address half.
// RULE_22: Enable bits without an interrupt source are written as zero.
// RULE_23: Edge select clear counts rising edges, set counts falling edges.
// RULE_24: Channel field enables pins 0 to N; output-configured pins are ignored.
// RULE_25: Event counting works only while its enable bit is set.
// RULE_26: Only the highest-priority pending flag is coded; others wait.
module xfer_event_counter
  import xfer_event_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Register port
  input  wire xfer_event_pkg::reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  // Event pins
  input  wire logic [7:0]            event_pin,
  // On-chip RAM
  output xfer_event_pkg::ram_req_t   ram_req,
  input  wire logic [15:0]           ram_rdata,
  // Event interrupt request and controller status
  output logic                       event_irq,
  output logic                       busy
);
  import xfer_event_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]  event_ctrl;
    logic [7:0]  counter_ctrl;
    logic [7:0]  enable_c;
    logic [7:0]  soft_vector;
    logic [7:0]  port_dir;
    logic [7:0]  pin_prev;
    logic [7:0]  pending;
    logic [7:0]  done_count;
    xfer_state_t state;
    logic        soft_job;
    logic [2:0]  slot;
    logic [2:0]  info_idx;
    logic [23:0] info_base;
    logic [23:0] data_addr;
    logic [15:0] data_word;
    logic [7:0]  rdata;
    ram_req_t    ram;
    logic        irq;
    logic        busy;
  } state_t;

  state_t cur;
  state_t nxt;

  logic [7:0] pin_enable;
  logic [7:0] edge_seen;
  logic [2:0] first_slot;
  logic       any_pending;
  logic       event_req;
  logic       soft_req;
  logic [7:0] clear_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state

  always_comb
  begin
    nxt         = cur;
    nxt.ram.rd  = 1'b0;
    nxt.ram.wr  = 1'b0;
    nxt.rdata   = 8'h00;
    clear_mask  = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Pin front end

    // Channel field enables pins 0..N, output pins masked [RULE_24]
    for (int i = 0; i < 8; i++)
    begin
      pin_enable[i] = (3'(i) <= cur.counter_ctrl[2:0]) && !cur.port_dir[i];
    end

    // Edge polarity from edge select [RULE_23]
    if (cur.counter_ctrl[EDGE_SELECT_BIT])
    begin
      edge_seen = cur.pin_prev & ~event_pin;
    end
    else
    begin
      edge_seen = ~cur.pin_prev & event_pin;
    end

    // Fixed order, pin 0 wins; only this slot is coded [RULE_09] [RULE_26]
    first_slot = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (cur.pending[i])
      begin
        first_slot = 3'(i);
      end
    end

    any_pending = |cur.pending;
    nxt.irq     = any_pending;                                           // [RULE_05]
    nxt.pin_prev = event_pin;

    // Mask level plays no part; only the enable bit routes it [RULE_14]
    event_req = any_pending && cur.enable_c[EVENT_ACT_EN_BIT];
    soft_req  = cur.soft_vector[SOFT_START_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Register port

    // Register write
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        OFS_EVENT_CTRL:
        begin
          // Only the counting enable is writable
          nxt.event_ctrl = reg_req.wdata & 8'h80;
        end
        OFS_COUNTER_CTRL:
        begin
          // Bits 6:4 read as zero; bit 3 keeps what was written
          nxt.counter_ctrl = reg_req.wdata & 8'h8F;
        end
        OFS_ENABLE_C:
        begin
          nxt.enable_c = reg_req.wdata;
        end
        OFS_SOFT_VECTOR:                                                  // [RULE_12]
        begin
          // A pending start locks the vector until its job has ended
          if (!cur.soft_vector[SOFT_START_BIT])
          begin
            nxt.soft_vector = reg_req.wdata;
          end
        end
        OFS_PORT_DIR:
        begin
          nxt.port_dir = reg_req.wdata;
        end
        default:
        begin
          // Read-only and unmapped offsets drop the write
        end
      endcase
    end

    // Register read, data in the following cycle
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        OFS_EVENT_CTRL:
        begin
          nxt.rdata = cur.event_ctrl;
        end
        OFS_COUNTER_CTRL:
        begin
          nxt.rdata = cur.counter_ctrl;
        end
        OFS_PENDING:
        begin
          // Live flags show events that are still waiting to be counted
          nxt.rdata = cur.pending;
        end
        OFS_ENABLE_C:
        begin
          nxt.rdata = cur.enable_c;
        end
        OFS_SOFT_VECTOR:
        begin
          nxt.rdata = cur.soft_vector;
        end
        OFS_PORT_DIR:
        begin
          nxt.rdata = cur.port_dir;
        end
        OFS_STATUS:
        begin
          // State code lets software see a job in flight
          nxt.rdata = {4'h0, cur.state};
        end
        OFS_DONE_COUNT:
        begin
          nxt.rdata = cur.done_count;
        end
        default:
        begin
          nxt.rdata = 8'h00;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    unique case (cur.state)
      ST_IDLE:
      begin
        // Software first, then ascending vector number [RULE_15]
        if (soft_req || event_req)
        begin
          nxt.soft_job = soft_req;
          nxt.slot     = first_slot;
          nxt.state    = ST_VEC_READ;
          nxt.ram.rd   = 1'b1;
          // Vector address = base + 2 * number [RULE_19] [RULE_20]
          if (soft_req)
          begin
            nxt.ram.addr = {8'h00, VECTOR_BASE + {8'h00, cur.soft_vector[6:0], 1'b0}};
          end
          else
          begin
            // The event request owns one fixed vector entry
            nxt.ram.addr = {8'h00, VECTOR_BASE + {8'h00, EVENT_VECTOR_NUM, 1'b0}};
          end
        end
      end
      ST_VEC_READ:
      begin
        // Entry holds low 16 bits of the start address [RULE_21]
        nxt.info_base = {INFO_PAGE[23:16], ram_rdata};
        nxt.info_idx  = 3'h0;
        nxt.ram.rd    = 1'b1;
        nxt.ram.addr  = {INFO_PAGE[23:16], ram_rdata};
        nxt.state     = ST_INFO_READ;
      end
      ST_INFO_READ:
      begin
        // Words: mode A/src hi, src lo, mode B/dst hi, dst lo, count A, count B [RULE_17]
        if (cur.info_idx == 3'h1)
        begin
          // Source word: slot replaces low five bits [RULE_07] [RULE_03]
          nxt.data_addr = {cur.data_addr[23:16], ram_rdata[15:5], 1'b0, cur.slot, 1'b0};
        end
        else if (cur.info_idx == 3'h0)
        begin
          // Low byte of the first word carries source bits 23:16
          nxt.data_addr[23:16] = ram_rdata[7:0];
        end
        if (cur.info_idx == INFO_WORDS - 3'h1)
        begin
          nxt.ram.rd   = 1'b1;
          nxt.ram.addr = nxt.data_addr;
          nxt.state    = ST_DATA_READ;
        end
        else
        begin
          nxt.info_idx = cur.info_idx + 3'h1;
          nxt.ram.rd   = 1'b1;
          nxt.ram.addr = cur.info_base + {20'h0, cur.info_idx + 3'h1, 1'b0};
        end
      end
      ST_DATA_READ:
      begin
        // Increment wraps to zero, no overflow signal [RULE_06] [RULE_11]
        nxt.data_word = ram_rdata + 16'h0001;
        nxt.state     = ST_DATA_WRITE;
      end
      ST_DATA_WRITE:
      begin
        // Write back to the same address [RULE_06]
        nxt.ram.wr    = 1'b1;
        nxt.ram.addr  = cur.data_addr;
        nxt.ram.wdata = cur.data_word;
        nxt.state     = ST_INFO_WRITE;
      end
      ST_INFO_WRITE:
      begin
        // Repeat mode leaves the information unchanged, so no write back is needed
        nxt.state = ST_FINISH;
      end
      ST_FINISH:
      begin
        nxt.done_count = cur.done_count + 8'h01;
        // Clear the activating flag or the start bit [RULE_13]
        if (cur.soft_job)
        begin
          nxt.soft_vector[SOFT_START_BIT] = 1'b0;
        end
        else
        begin
          clear_mask[cur.slot] = 1'b1;                                    // [RULE_08]
        end
        nxt.state = ST_IDLE;
      end
      default: nxt.state = ST_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Pending flags and status

    // Flags: clear wins over a same-cycle edge; pending pins drop further edges [RULE_04] [RULE_10]
    if (cur.event_ctrl[EVENT_ENABLE_BIT])                                 // [RULE_25]
    begin
      nxt.pending = (cur.pending & ~clear_mask) | (edge_seen & pin_enable & ~cur.pending);
    end
    else
    begin
      // Turning counting off drops every event not yet counted
      nxt.pending = 8'h00;
    end

    // Busy has its own flop so the output carries no decode glitches
    nxt.busy = (nxt.state != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cur              <= '0;
      cur.event_ctrl   <= RST_EVENT_CTRL;
      cur.counter_ctrl <= RST_COUNTER_CTRL;
      cur.enable_c     <= RST_ENABLE_C;
      cur.soft_vector  <= RST_SOFT_VECTOR;
      cur.port_dir     <= RST_PORT_DIR;
      cur.state        <= ST_IDLE;
    end
    else
    begin
      cur <= nxt;
    end
  end

  assign reg_rdata = cur.rdata;
  assign ram_req   = cur.ram;
  assign event_irq = cur.irq;
  assign busy      = cur.busy;

endmodule

// File: xfer_event_sva.sv
// Checker: port properties of the event transfer front end
`timescale 1ns/1ns
module xfer_event_sva
  import xfer_event_pkg::*;
(
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     reset_n,
  // Watched ports
  input wire xfer_event_pkg::reg_req_t reg_req,
  input wire logic [7:0]               reg_rdata,
  input wire logic [7:0]               event_pin,
  input wire xfer_event_pkg::ram_req_t ram_req,
  input wire logic [15:0]              ram_rdata,
  input wire logic                     event_irq,
  input wire logic                     busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [5:0] busy_run;
  // Counts busy cycles so a hung job shows without an unbounded wait
  always_ff @(posedge mclk)
  begin
    busy_run <= (!reset_n || !busy) ? 6'h00 : busy_run + 6'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_irq_starts_job: assert property ($rose(event_irq) |-> ##[0:3] busy)
    else $error("event request started no job");
  chk_vector_first: assert property ($rose(busy) |->
    ##[0:1] (ram_req.rd && ram_req.addr[23:8] == 16'h0004)) else $error("no vector read first");
  chk_rmw_pair: assert property (ram_req.wr |->
    $past(ram_req.rd, 2) && ram_req.addr == $past(ram_req.addr, 2)) else $error("write not paired");
  chk_incr_data: assert property (ram_req.wr |->
    ram_req.wdata == $past(ram_rdata, 2) + 16'h0001)
    else $error("written count not read plus one");
  chk_slot_code: assert property (ram_req.wr |->
    ram_req.addr[4:0] <= 5'h0E && !ram_req.addr[0]) else $error("bad slot code");
  chk_one_strobe: assert property (!(ram_req.rd && ram_req.wr))
    else $error("read and write together");
  chk_ram_quiet: assert property (!busy |-> !ram_req.rd && !ram_req.wr)
    else $error("RAM access while idle");
  chk_job_bounded: assert property (busy_run < 6'h20)
    else $error("job did not finish");
endmodule
bind xfer_event_counter xfer_event_sva chk (.mclk(mclk), .reset_n(reset_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .event_pin(event_pin), .ram_req(ram_req), .ram_rdata(ram_rdata),
  .event_irq(event_irq), .busy(busy));

// File: xfer_ram_model.sv
// Partner model: on-chip RAM, word read data half a cycle later, within the request cycle
`timescale 1ns/1ns
module xfer_ram_model
  import xfer_event_pkg::*;
(
  // Clock and RAM port
  input  wire logic                     mclk,
  input  wire xfer_event_pkg::ram_req_t ram_req,
  output logic [15:0]                   ram_rdata
);
  logic [15:0] mem [logic [23:0]];
  logic [23:0] rd_log [$];
  logic [23:0] wr_log [$];
  initial ram_rdata = 16'h5A5A;
  // Read data settles mid-cycle while the request stands; idle cycles flip the bus
  always @(negedge mclk)
  begin
    ram_rdata <= ram_req.rd ? (mem.exists(ram_req.addr) ? mem[ram_req.addr] : 16'h0000)
                            : ~ram_rdata;
  end
  always @(posedge mclk)
  begin
    if (ram_req.rd)
      rd_log.push_back(ram_req.addr);
    if (ram_req.wr)
    begin
      mem[ram_req.addr] = ram_req.wdata;
      wr_log.push_back(ram_req.addr);
    end
  end
endmodule

// File: xfer_event_counter_tb_top.sv
// Testbench: event counting, priority, lost edges and soft activation
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module xfer_event_counter_tb_top;
  import xfer_event_pkg::*;
  localparam logic [23:0] BASE = 24'hFFED00;
  logic        mclk      = 1'b0;
  logic        reset_n   = 1'b0;
  reg_req_t    reg_req   = '0;
  logic [7:0]  event_pin = 8'h00;
  ram_req_t    ram_req;
  logic [15:0] ram_rdata;
  logic [7:0]  reg_rdata;
  logic        event_irq;
  logic        busy;
  int          errors    = 0;
  int          n_checks  = 0;
  logic [15:0] exp_cnt [8];
  always #20 mclk = ~mclk;
  xfer_event_counter dut (.mclk(mclk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .event_pin(event_pin), .ram_req(ram_req), .ram_rdata(ram_rdata), .event_irq(event_irq),
    .busy(busy));
  xfer_ram_model ram (.mclk(mclk), .ram_req(ram_req), .ram_rdata(ram_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_req <= '0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask
  // Idle needs both flags low for a few cycles: the request lags its flags
  task automatic wait_idle();
    int q;
    q = 0;
    repeat (600)
    begin
      @(posedge mclk);
      #1 q = (busy === 1'b0 && event_irq === 1'b0) ? q + 1 : 0;
      if (q == 4)
        break;
    end
    `CHK("idle", 1'b1, q == 4)
  endtask
  task automatic ev_round(input logic en, fall, input logic [2:0] ch,
                          input logic [7:0] dir, hit, input logic dbl);
    logic [7:0] idle;
    logic [7:0] used;
    idle = {8{fall}};
    used = (8'hFF >> (3'h7 - ch)) & ~dir & hit & {8{en}};
    reg_wr(OFS_EVENT_CTRL, 8'h00);
    event_pin <= idle;
    reg_wr(OFS_COUNTER_CTRL, {fall, 4'h0, ch});
    reg_wr(OFS_PORT_DIR, dir);
    reg_wr(OFS_ENABLE_C, 8'h10);
    reg_wr(OFS_EVENT_CTRL, {en, 7'h00});
    for (int n = 0; n < 8; n++)
      exp_cnt[n] = ram.mem[BASE + 24'(2 * n)] + 16'(used[n]);
    ram.rd_log.delete();
    ram.wr_log.delete();
    repeat (dbl ? 2 : 1)
    begin
      @(posedge mclk);
      event_pin <= idle ^ hit;
      @(posedge mclk);
      event_pin <= idle;
    end
    wait_idle();
    for (int n = 0; n < 8; n++)
      `CHK("count", exp_cnt[n], ram.mem[BASE + 24'(2 * n)])
    for (int i = 1; i < ram.wr_log.size(); i++)
      `CHK("order", 1'b1, ram.wr_log[i] > ram.wr_log[i - 1])
    if (used != 8'h00)
      `CHK("vector", 24'h00043A, ram.rd_log[0])
    `CHK("jobs", $countones(used), ram.wr_log.size())
    $display("test round %h done", used);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] d;
    ram.mem[24'h00043A] = 16'hEC00;
    ram.mem[24'h000420] = 16'hEC00;
    ram.mem[24'hFFEC00] = 16'h05FF;
    ram.mem[24'hFFEC02] = 16'hED00;
    ram.mem[24'hFFEC04] = 16'h00FF;
    ram.mem[24'hFFEC06] = 16'hED00;
    for (int n = 0; n < 8; n++)
      ram.mem[BASE + 24'(2 * n)] = 16'(n * 16'h0111);
    ram.mem[BASE + 24'h00000E] = 16'hFFFF;
    void'($urandom(32'hC13B));
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 9; a++)
    begin
      reg_rd(a[3:0], d);
      `CHK("reset_reg", 8'h00, d)
    end
    $display("test reset done");
    // Wrap on pin 7 with double edges, counting off, falling edge with an output pin
    ev_round(1'b1, 1'b0, 3'h7, 8'h00, 8'hFF, 1'b1);
    ev_round(1'b0, 1'b0, 3'h7, 8'h00, 8'hFF, 1'b0);
    ev_round(1'b1, 1'b1, 3'h2, 8'h02, 8'hFF, 1'b0);
    repeat (6)
      ev_round(1'b1, 1'($urandom), 3'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
    ram.rd_log.delete();
    reg_wr(OFS_SOFT_VECTOR, 8'h90);
    reg_wr(OFS_SOFT_VECTOR, 8'h85);
    wait_idle();
    `CHK("soft_vec", 24'h000420, ram.rd_log[0])
    for (int i = 1; i < 7; i++)
      `CHK("info_addr", 24'hFFEC00 + 24'(2 * (i - 1)), ram.rd_log[i])
    reg_rd(OFS_SOFT_VECTOR, d);
    `CHK("soft_clear", 8'h10, d)
    $display("test soft done");
    print_verdict();
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    errors++;
    print_verdict();
  end
endmodule
